/* hw/mne_pkg.sv */
// Shared constants and types for the multiply and negate execution datapath
package mne_pkg;
    localparam int DW = 8;
    localparam int AW = 12;
    localparam int IW = 16;
    // Opcode patterns on the upper instruction bits
    localparam logic [7:0] IMM_PRODUCT_OP = 8'h0D;
    localparam logic [6:0] REG_PRODUCT_OP = 7'h01;
    localparam logic [6:0] TWOS_NEGATE_OP = 7'h36;
    // Operand addressing
    localparam logic [7:0] INDEXED_LIMIT = 8'h5F;
    localparam logic [7:0] ACCESS_SPLIT_STD = 8'h80;
    localparam logic [7:0] ACCESS_SPLIT_EXT = 8'h60;
    localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
    localparam logic [3:0] NIBBLE_ZERO = 4'h0;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] BYTE_ONE = 8'h01;
    localparam logic [7:0] SIGN_ONLY = 8'h80;
    localparam logic [15:0] PROD_RESET = 16'h0000;
    localparam logic [11:0] ADDR_RESET = 12'h000;

    typedef enum logic [3:0] {
        MNE_Q1 = 4'b0001,
        MNE_Q2 = 4'b0010,
        MNE_Q3 = 4'b0100,
        MNE_Q4 = 4'b1000
    } mne_phase_t;

    typedef enum logic [2:0] {
        MNE_OP_NONE = 3'b000,
        MNE_OP_IMM = 3'b001,
        MNE_OP_REG = 3'b010,
        MNE_OP_NEG = 3'b100
    } mne_op_t;

    typedef struct packed {
        logic negative;
        logic signed_wrap_flag;
        logic carry;
        logic half_carry_flag;
        logic zero;
    } mne_flags_t;

    typedef struct packed {
        logic [DW-1:0] product_upper;
        logic [DW-1:0] product_lower;
    } mne_prod_t;

    localparam mne_flags_t FLAGS_RESET = '0;
endpackage : mne_pkg

/* hw/mne_execute.sv */
// Quarter-cycle execution datapath for immediate/register multiply and negate
//
// What this block does
// - Immediate multiply opcode multiplies working register by 8-bit immediate, unsigned.
// - Both multiplies write 16-bit product, high byte upper, low byte lower.
// - Multiplies never touch working register or any status flag.
// - No zero, carry or overflow indication from a multiply.
// - Register multiply multiplies working register by addressed register, sources untouched.
// - Access bit 0 picks access bank; 1 uses bank pointer.
// - Access bit 0 with extended set and field <= 5Fh uses indexed offset.
// - Negate writes the two's complement back to the addressed byte.
// - Negate updates negative, wrap, carry, half-carry and zero flags.
// - Immediate multiply takes any immediate 0..255 in one program word.
`timescale 1ns/1ns
module mne_execute #(
    parameter int DW = mne_pkg::DW,
    parameter int AW = mne_pkg::AW
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_arst_n,
    // Instruction from decoder, sampled in Q1
    input wire logic i_instr_valid,
    input wire logic [mne_pkg::IW-1:0] i_instr,
    // Core state
    input wire logic [DW-1:0] i_wreg,
    input wire logic [3:0] i_bank_pointer,
    input wire logic i_ext_en,
    input wire logic [AW-1:0] i_index_base,
    // Data memory
    input wire logic [DW-1:0] i_mem_rdata,
    output logic [AW-1:0] o_mem_addr,
    output logic o_mem_rd,
    output logic o_mem_we,
    output logic [DW-1:0] o_mem_wdata,
    // Results
    output mne_pkg::mne_prod_t o_prod,
    output logic o_prod_we,
    output mne_pkg::mne_flags_t o_flags,
    output logic o_flags_we,
    // Phase
    output logic o_q1
);
    mne_pkg::mne_phase_t phase_r, phase_nxt;
    mne_pkg::mne_op_t op_r, op_nxt;
    logic [DW-1:0] imm_r, imm_nxt;
    logic [DW-1:0] opnd_r, opnd_nxt;
    logic [AW-1:0] addr_r, addr_nxt;
    mne_pkg::mne_prod_t prod_r, prod_nxt;
    logic [DW-1:0] wdata_r, wdata_nxt;
    mne_pkg::mne_flags_t flags_r, flags_nxt;

    function automatic mne_pkg::mne_op_t decode_op(input logic [mne_pkg::IW-1:0] ins);
        if (ins[15:8] == mne_pkg::IMM_PRODUCT_OP) begin
            return mne_pkg::MNE_OP_IMM;
        end else if (ins[15:9] == mne_pkg::REG_PRODUCT_OP) begin
            return mne_pkg::MNE_OP_REG;
        end else if (ins[15:9] == mne_pkg::TWOS_NEGATE_OP) begin
            return mne_pkg::MNE_OP_NEG;
        end else begin
            return mne_pkg::MNE_OP_NONE;
        end
    endfunction : decode_op

    function automatic logic [AW-1:0] resolve_addr(
        input logic acc, input logic [7:0] f, input logic ext,
        input logic [3:0] bank, input logic [AW-1:0] base);
        logic [7:0] split;
        split = ext ? mne_pkg::ACCESS_SPLIT_EXT : mne_pkg::ACCESS_SPLIT_STD;
        if (acc) begin
            return AW'({bank, f});
        end else if (ext && f <= mne_pkg::INDEXED_LIMIT) begin
            return AW'(base + AW'(f));
        end else if (f < split) begin
            return AW'({mne_pkg::ACCESS_LOW_BANK, f});
        end else begin
            return AW'({mne_pkg::ACCESS_HIGH_BANK, f});
        end
    endfunction : resolve_addr

    // Phase sequencer and compute
    always_comb begin
        logic [DW-1:0] neg;
        neg = ~opnd_r + mne_pkg::BYTE_ONE;
        phase_nxt = phase_r;
        op_nxt = op_r;
        imm_nxt = imm_r;
        opnd_nxt = opnd_r;
        addr_nxt = addr_r;
        prod_nxt = prod_r;
        wdata_nxt = wdata_r;
        flags_nxt = flags_r;
        case (phase_r)
            mne_pkg::MNE_Q1: begin
                phase_nxt = mne_pkg::MNE_Q2;
                op_nxt = i_instr_valid ? decode_op(i_instr) : mne_pkg::MNE_OP_NONE;
                imm_nxt = i_instr[7:0];
                addr_nxt = resolve_addr(i_instr[8], i_instr[7:0], i_ext_en,
                                        i_bank_pointer, i_index_base);
            end
            mne_pkg::MNE_Q2: begin
                phase_nxt = mne_pkg::MNE_Q3;
                opnd_nxt = (op_r == mne_pkg::MNE_OP_IMM) ? imm_r : i_mem_rdata;
            end
            mne_pkg::MNE_Q3: begin
                phase_nxt = mne_pkg::MNE_Q4;
                if (op_r == mne_pkg::MNE_OP_IMM || op_r == mne_pkg::MNE_OP_REG) begin
                    // Zero-extended operands keep the full 16-bit product
                    prod_nxt = mne_pkg::mne_prod_t'((2*DW)'(i_wreg) * (2*DW)'(opnd_r));
                end else if (op_r == mne_pkg::MNE_OP_NEG) begin
                    wdata_nxt = neg;
                    flags_nxt.negative = neg[DW-1];
                    flags_nxt.signed_wrap_flag = (opnd_r == mne_pkg::SIGN_ONLY);
                    flags_nxt.carry = (opnd_r == mne_pkg::BYTE_ZERO);
                    flags_nxt.half_carry_flag = (opnd_r[3:0] == mne_pkg::NIBBLE_ZERO);
                    flags_nxt.zero = (neg == mne_pkg::BYTE_ZERO);
                end
            end
            mne_pkg::MNE_Q4: begin
                phase_nxt = mne_pkg::MNE_Q1;
            end
            default: begin
                phase_nxt = mne_pkg::MNE_Q1;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            phase_r <= mne_pkg::MNE_Q1;
            op_r <= mne_pkg::MNE_OP_NONE;
            imm_r <= mne_pkg::BYTE_ZERO;
            opnd_r <= mne_pkg::BYTE_ZERO;
            addr_r <= mne_pkg::ADDR_RESET;
            prod_r <= mne_pkg::PROD_RESET;
            wdata_r <= mne_pkg::BYTE_ZERO;
            flags_r <= mne_pkg::FLAGS_RESET;
        end else begin
            phase_r <= phase_nxt;
            op_r <= op_nxt;
            imm_r <= imm_nxt;
            opnd_r <= opnd_nxt;
            addr_r <= addr_nxt;
            prod_r <= prod_nxt;
            wdata_r <= wdata_nxt;
            flags_r <= flags_nxt;
        end
    end

    // Strobes; multiplies never raise the flag write or the memory write
    assign o_q1 = (phase_r == mne_pkg::MNE_Q1);
    assign o_mem_rd = (phase_r == mne_pkg::MNE_Q2) &&
                      (op_r == mne_pkg::MNE_OP_REG || op_r == mne_pkg::MNE_OP_NEG);
    assign o_prod_we = (phase_r == mne_pkg::MNE_Q4) &&
                       (op_r == mne_pkg::MNE_OP_IMM || op_r == mne_pkg::MNE_OP_REG);
    assign o_mem_we = (phase_r == mne_pkg::MNE_Q4) && (op_r == mne_pkg::MNE_OP_NEG);
    assign o_flags_we = o_mem_we;
    assign o_mem_addr = addr_r;
    assign o_mem_wdata = wdata_r;
    assign o_prod = prod_r;
    assign o_flags = flags_r;

    // Checks
    phase_cycle_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        o_q1 |=> phase_r == mne_pkg::MNE_Q2 ##1 phase_r == mne_pkg::MNE_Q3
                 ##1 phase_r == mne_pkg::MNE_Q4 ##1 o_q1)
        else $error("quarter phases out of order");
    imm_product_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        o_q1 && i_instr_valid && i_instr[15:8] == mne_pkg::IMM_PRODUCT_OP |->
        ##3 o_prod_we && o_prod == 16'($past(i_wreg, 1)) * 16'($past(i_instr[7:0], 3)))
        else $error("immediate product wrong");
    product_split_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        o_prod_we |->
        o_prod.product_upper == 8'((16'($past(i_wreg)) * 16'($past(opnd_r))) >> 8) &&
        o_prod.product_lower == 8'(16'($past(i_wreg)) * 16'($past(opnd_r))))
        else $error("product bytes swapped");
    mult_no_flags_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        o_prod_we |-> !o_flags_we && !o_mem_we && $stable(o_flags))
        else $error("multiply touched flags or memory");
    mult_no_zero_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        o_prod_we && o_prod == mne_pkg::PROD_RESET |-> !o_flags_we)
        else $error("zero product flagged");
    reg_product_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        o_mem_rd && op_r == mne_pkg::MNE_OP_REG |->
        ##2 o_prod_we && !o_mem_we &&
        o_prod == 16'($past(i_wreg, 1)) * 16'($past(i_mem_rdata, 2)))
        else $error("register product wrong");
    bank_select_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        o_q1 && i_instr[8] |=> o_mem_addr == {$past(i_bank_pointer), $past(i_instr[7:0])})
        else $error("bank pointer address wrong");
    access_bank_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        o_q1 && !i_instr[8] && !i_ext_en && i_instr[7:0] < mne_pkg::ACCESS_SPLIT_STD |=>
        o_mem_addr == {mne_pkg::ACCESS_LOW_BANK, $past(i_instr[7:0])})
        else $error("access bank address wrong");
    invalid_quiet_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        o_q1 && !i_instr_valid |-> ##3 !o_prod_we && !o_mem_we && !o_flags_we)
        else $error("idle slot wrote a result");
    indexed_mode_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        o_q1 && !i_instr[8] && i_ext_en && i_instr[7:0] <= mne_pkg::INDEXED_LIMIT |=>
        o_mem_addr == AW'($past(i_index_base) + AW'($past(i_instr[7:0]))))
        else $error("indexed offset address wrong");
    negate_value_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        o_mem_rd && op_r == mne_pkg::MNE_OP_NEG |->
        ##2 o_mem_we && o_mem_wdata == DW'(-$past(i_mem_rdata, 2)))
        else $error("negate result wrong");
    negate_flags_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        o_flags_we |-> o_flags.zero == (o_mem_wdata == mne_pkg::BYTE_ZERO) &&
        o_flags.negative == o_mem_wdata[DW-1] &&
        o_flags.carry == (o_mem_wdata == mne_pkg::BYTE_ZERO) &&
        o_flags.signed_wrap_flag == (o_mem_wdata == mne_pkg::SIGN_ONLY) &&
        o_flags.half_carry_flag == (o_mem_wdata[3:0] == mne_pkg::NIBBLE_ZERO))
        else $error("negate flags wrong");
    // Main scenarios
    cover_imm_c: cover property (@(posedge i_clk) disable iff (!i_arst_n)
        o_prod_we && op_r == mne_pkg::MNE_OP_IMM);
    cover_reg_c: cover property (@(posedge i_clk) disable iff (!i_arst_n)
        o_prod_we && op_r == mne_pkg::MNE_OP_REG);
    cover_neg_c: cover property (@(posedge i_clk) disable iff (!i_arst_n)
        o_flags_we && o_flags.signed_wrap_flag);
    cover_carry_c: cover property (@(posedge i_clk) disable iff (!i_arst_n)
        o_flags_we && o_flags.carry);
    cover_idle_c: cover property (@(posedge i_clk) disable iff (!i_arst_n)
        o_q1 && !i_instr_valid);
endmodule : mne_execute

/* verif/tb.sv */
// Self-checking testbench for the multiply and negate execution datapath
`timescale 1ns/1ns
`define CHK(got, exp, msg) begin n_tests++; if ((got) !== (exp)) begin fails++; \
    $display("wrong value at %0t ns: %s", $time, msg); end end
module tb;
    logic i_clk = 1'b0;
    logic i_arst_n = 1'b0;
    logic i_instr_valid = 1'b0;
    logic [15:0] i_instr = 16'h0000;
    logic [7:0] i_wreg = 8'h00;
    logic [3:0] i_bank_pointer = 4'h0;
    logic i_ext_en = 1'b0;
    logic [11:0] i_index_base = 12'h000;
    logic [7:0] i_mem_rdata = 8'h00;
    logic [11:0] o_mem_addr;
    logic o_mem_rd;
    logic o_mem_we;
    logic [7:0] o_mem_wdata;
    mne_pkg::mne_prod_t o_prod;
    logic o_prod_we;
    mne_pkg::mne_flags_t o_flags;
    logic o_flags_we;
    logic o_q1;
    int fails = 0;
    int n_tests = 0;

    mne_execute u_dut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_instr_valid(i_instr_valid),
        .i_instr(i_instr), .i_wreg(i_wreg), .i_bank_pointer(i_bank_pointer),
        .i_ext_en(i_ext_en), .i_index_base(i_index_base), .i_mem_rdata(i_mem_rdata),
        .o_mem_addr(o_mem_addr), .o_mem_rd(o_mem_rd), .o_mem_we(o_mem_we),
        .o_mem_wdata(o_mem_wdata), .o_prod(o_prod), .o_prod_we(o_prod_we),
        .o_flags(o_flags), .o_flags_we(o_flags_we), .o_q1(o_q1));

    always #2 i_clk = ~i_clk;

    task automatic test_done;
        if (fails == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done

    // One instruction, kind 0 none, 1 immediate, 2 register multiply, 3 negate
    task automatic op(input logic v, input logic [15:0] ins, input logic [7:0] w,
                      input logic [7:0] rd, input logic [11:0] ea, input logic [1:0] kind);
        logic [7:0] opnd;
        logic [15:0] ep;
        logic [7:0] neg;
        opnd = (kind == 2'h1) ? ins[7:0] : rd;
        ep = {8'h00, w} * {8'h00, opnd};
        neg = 8'h00 - rd;
        while (o_q1 !== 1'b1) begin
            @(posedge i_clk);
            #1;
        end
        i_instr_valid = v;
        i_instr = ins;
        i_wreg = w;
        i_mem_rdata = rd;
        @(posedge i_clk);
        #1;
        `CHK(o_q1, 1'b0, "phase after take")
        `CHK(o_mem_rd, kind[1], "read strobe in second quarter")
        if (kind[1]) `CHK(o_mem_addr, ea, "operand address")
        @(posedge i_clk);
        #1;
        `CHK(o_prod_we, 1'b0, "no product write in third quarter")
        @(posedge i_clk);
        #1;
        `CHK(o_prod_we, kind == 2'h1 || kind == 2'h2, "product write strobe")
        `CHK(o_mem_we, kind == 2'h3, "memory write strobe")
        `CHK(o_flags_we, kind == 2'h3, "flag write strobe")
        if (kind == 2'h1 || kind == 2'h2) `CHK(o_prod, ep, "product value")
        if (kind == 2'h3) begin
            `CHK(o_mem_wdata, neg, "negated byte")
            `CHK(o_flags, {neg[7], rd == 8'h80, rd == 8'h00, rd[3:0] == 4'h0,
                neg == 8'h00}, "negate flags")
        end
        @(posedge i_clk);
        #1;
        `CHK(o_q1, 1'b1, "back in first quarter")
    endtask : op

    task automatic t_imm;
        op(1'b1, 16'h0DC4, 8'hE2, 8'h00, 12'h000, 2'h1);
        op(1'b1, 16'h0DFF, 8'hFF, 8'h5A, 12'h000, 2'h1);
        op(1'b1, 16'h0D00, 8'h37, 8'h00, 12'h000, 2'h1);
    endtask : t_imm

    task automatic t_regmul;
        i_bank_pointer = 4'h2;
        op(1'b1, 16'h03A0, 8'hC4, 8'hB5, 12'h2A0, 2'h2);
        op(1'b1, 16'h0210, 8'h00, 8'hFF, 12'h010, 2'h2);
        op(1'b1, 16'h0290, 8'h81, 8'h03, 12'hF90, 2'h2);
    endtask : t_regmul

    task automatic t_index;
        i_ext_en = 1'b1;
        i_index_base = 12'h100;
        op(1'b1, 16'h025F, 8'h10, 8'h10, 12'h15F, 2'h2);
        op(1'b1, 16'h6C60, 8'h00, 8'h01, 12'hF60, 2'h3);
        op(1'b1, 16'h6D10, 8'h00, 8'h22, 12'h210, 2'h3);
        i_ext_en = 1'b0;
        op(1'b1, 16'h6C10, 8'h00, 8'h44, 12'h010, 2'h3);
        op(1'b1, 16'h0270, 8'h02, 8'h44, 12'h070, 2'h2);
    endtask : t_index

    task automatic t_neg;
        i_bank_pointer = 4'h2;
        op(1'b1, 16'h6D10, 8'h00, 8'h3A, 12'h210, 2'h3);
        op(1'b1, 16'h6D11, 8'h00, 8'h00, 12'h211, 2'h3);
        op(1'b1, 16'h6D12, 8'h00, 8'h80, 12'h212, 2'h3);
        op(1'b1, 16'h6D13, 8'h00, 8'h10, 12'h213, 2'h3);
    endtask : t_neg

    task automatic t_ignore;
        op(1'b0, 16'h0DC4, 8'hE2, 8'h00, 12'h000, 2'h0);
        op(1'b1, 16'h0E55, 8'hE2, 8'h00, 12'h000, 2'h0);
    endtask : t_ignore

    task automatic t_reset;
        while (o_q1 !== 1'b1) begin
            @(posedge i_clk);
            #1;
        end
        i_instr_valid = 1'b1;
        i_instr = 16'h6D10;
        i_mem_rdata = 8'h3A;
        repeat (3) @(posedge i_clk);
        #1;
        i_arst_n = 1'b0;
        #1;
        `CHK(o_q1, 1'b1, "phase after reset")
        `CHK(o_mem_we, 1'b0, "no write under reset")
        `CHK(o_flags, 5'h00, "flags cleared by reset")
        `CHK(o_prod, 16'h0000, "product cleared by reset")
        repeat (2) @(posedge i_clk);
        #1;
        i_arst_n = 1'b1;
        op(1'b1, 16'h0DC4, 8'hE2, 8'h00, 12'h000, 2'h1);
    endtask : t_reset

    initial begin
        #20000;
        fails++;
        test_done();
    end

    initial begin
        repeat (5) @(posedge i_clk);
        #1;
        i_arst_n = 1'b1;
        t_imm();
        t_regmul();
        t_index();
        t_neg();
        t_ignore();
        t_reset();
        test_done();
    end
endmodule : tb
